//--- hdl/wlv_pkg.sv
`default_nettype none
package wlv_pkg;

  // ==========================================================
  // Clock and leveling timing
  localparam int CLK_MHZ = 125;
  // Longest times: cycle counts round down, never below one
  localparam int FB_DELAY_NS = 9;
  localparam int SETTLE_DELAY_NS = 2;
  localparam int FB_DELAY_CYC =
    (FB_DELAY_NS * CLK_MHZ / 1000 > 0) ? FB_DELAY_NS * CLK_MHZ / 1000 : 1;
  localparam int SETTLE_DELAY_CYC =
    (SETTLE_DELAY_NS * CLK_MHZ / 1000 > 0) ? SETTLE_DELAY_NS * CLK_MHZ / 1000 : 1;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] FB_CNT = CNT_W'(FB_DELAY_CYC);
  localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(SETTLE_DELAY_CYC);

  // ==========================================================
  // Register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] CAPS_OFS = 8'h08;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // Nominal termination codes
  localparam logic [2:0] RTT_OFF = 3'h0;
  localparam logic [2:0] RTT_60 = 3'h1;
  localparam logic [2:0] RTT_120 = 3'h2;
  localparam logic [2:0] RTT_40 = 3'h3;

  // Data lane layout
  localparam logic [15:0] PRIME_MASK = 16'h0101;
  localparam logic [15:0] LANE_MASK_X8 = 16'h00ff;
  localparam logic [15:0] LANE_MASK_X16 = 16'hffff;

  typedef struct packed {
    logic x16;
    logic [2:0] rtt;
    logic out_dis;
    logic lvl_en;
  } wlv_ctrl_t;

  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_STBY = 5'b00010,
    ST_ARMED = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_DONE = 5'b10000
  } wlv_state_t;

  typedef struct packed {
    wlv_state_t st;
    logic rtt_bad;
    logic [1:0] fb;
  } wlv_stat_t;

endpackage
`default_nettype wire

//--- hdl/wlv_sync.sv
`timescale 1ns/1ps
`default_nettype none
module wlv_sync import wlv_pkg::*; #(
  parameter int W = 4
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ==========================================================
  // Two-stage synchroniser; only the second stage leaves
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // wlv_sync
`default_nettype wire

//--- hdl/wlv_lane.sv
`timescale 1ns/1ps
`default_nettype none
module wlv_lane import wlv_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic en_in,
  input wire logic dqs_in,
  input wire logic ck_in,
  output logic cap_out,
  output logic fb_out,
  output logic upd_out
);

  localparam int CHK_FB = FB_DELAY_CYC + 1;

  logic dqs_prev_q;
  logic smp_q;
  logic fb_q;
  logic upd_q;
  logic [CNT_W-1:0] cnt_q;
  logic cap;

  // ==========================================================
  // Strobe capture
  // An edge inside a running feedback delay is dropped; legal
  // pulse widths keep edges further apart than that delay
  assign cap = en_in && dqs_in && !dqs_prev_q && (cnt_q == '0);

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      dqs_prev_q <= 1'b0;
    end else begin
      dqs_prev_q <= dqs_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      smp_q <= 1'b0;
    end else if (cap) begin
      smp_q <= ck_in;
    end
  end

  // ==========================================================
  // Feedback delay
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      cnt_q <= '0;
      fb_q <= 1'b0;
      upd_q <= 1'b0;
    end else begin
      upd_q <= (cnt_q == CNT_W'(1));
      if (cap) begin
        cnt_q <= FB_CNT;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
      if (cnt_q == CNT_W'(1)) begin
        fb_q <= smp_q;
      end
    end
  end

  assign cap_out = cap;
  assign fb_out = fb_q;
  assign upd_out = upd_q;

  // ==========================================================
  // Checks
  sequence s_capture;
    cap;
  endsequence

  chk_sample_ck: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    s_capture |=> (smp_q == $past(ck_in)))
    else $error("strobe edge did not sample the clock level");

  chk_fb_delay: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    s_capture |-> ##CHK_FB (upd_q && fb_q == $past(smp_q)))
    else $error("feedback not presented after the feedback delay");

endmodule // wlv_lane
`default_nettype wire

//--- hdl/wlv_level.sv
`timescale 1ns/1ps
`default_nettype none
module wlv_level import wlv_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic ck_in,
  input wire logic odt_in,
  input wire logic [1:0] dqs_in,
  output logic [15:0] dq_out,
  output logic [15:0] dq_oe_out,
  output logic dqs_rx_en_out,
  output logic [1:0] dqs_term_en_out,
  output logic dq_term_en_out
);

  localparam int CHK_SET = SETTLE_DELAY_CYC;

  logic [3:0] pin_s;
  logic ck_s;
  logic odt_s;
  logic [1:0] dqs_s;
  wlv_ctrl_t ctrl_q;
  wlv_state_t st_q;
  wlv_state_t st_d;
  logic [CNT_W-1:0] set_cnt_q;
  logic [CNT_W-1:0] set_cnt_d;
  logic [15:0] dq_q;
  logic [15:0] dq_d;
  logic [15:0] lane_mask;
  logic [15:0] fb_bits;
  logic [1:0] lane_on;
  logic [1:0] cap;
  logic [1:0] fb;
  logic [1:0] upd;
  logic [1:0] dqs_term_q;
  logic dq_term_q;
  logic [7:0] caps_q [2];
  logic rtt_bad_q;
  logic lvl_live;
  logic active;
  logic rtt_on;
  logic rtt_ok;
  logic setup;
  logic access;
  logic [31:0] rdata_q;
  logic err_q;
  logic [31:0] rd_mux;
  logic rd_err;
  wlv_stat_t stat;

  // ==========================================================
  // Pin synchronisation
  wlv_sync #(
    .W(4)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in({ck_in, odt_in, dqs_in}),
    .sync_out(pin_s)
  );

  assign ck_s = pin_s[3];
  assign odt_s = pin_s[2];
  assign dqs_s = pin_s[1:0];

  // ==========================================================
  // Mode decode
  assign lvl_live = ctrl_q.lvl_en && !ctrl_q.out_dis;
  assign active = (st_q == ST_ARMED) || (st_q == ST_WAIT) || (st_q == ST_DONE);
  assign rtt_on = (ctrl_q.rtt != RTT_OFF);
  assign rtt_ok = (ctrl_q.rtt == RTT_40) || (ctrl_q.rtt == RTT_60) || (ctrl_q.rtt == RTT_120);
  assign lane_mask = ctrl_q.x16 ? LANE_MASK_X16 : LANE_MASK_X8;

  // ==========================================================
  // Byte lanes
  generate
    for (genvar i = 0; i < 2; i++) begin : g_lane
      // Upper lane exists only in the wide configuration
      assign lane_on[i] = (i == 0) ? 1'b1 : ctrl_q.x16;

      wlv_lane u_lane (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .en_in(active && lane_on[i]),
        .dqs_in(dqs_s[i]),
        .ck_in(ck_s),
        .cap_out(cap[i]),
        .fb_out(fb[i]),
        .upd_out(upd[i])
      );

      always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
          dqs_term_q[i] <= 1'b0;
        end else begin
          dqs_term_q[i] <= odt_s && rtt_on && lane_on[i];
        end
      end

      // Capture count per lane, cleared by a write to it with that lane's strobe bit set; a capture in the same cycle wins and counts up
      always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
          caps_q[i] <= 8'h00;
        end else if (cap[i]) begin
          caps_q[i] <= caps_q[i] + 8'h01;
        end else if (access && pwrite_in && paddr_in == CAPS_OFS && pstrb_in[i]) begin
          caps_q[i] <= 8'h00;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Leveling state machine
  always_comb begin
    st_d = st_q;
    set_cnt_d = set_cnt_q;
    if (!ctrl_q.lvl_en) begin
      st_d = ST_OFF;
    end else if (ctrl_q.out_dis) begin
      st_d = ST_STBY;
    end else begin
      case (st_q)
        ST_OFF, ST_STBY: begin
          st_d = ST_ARMED;
        end
        ST_ARMED: begin
          if (|upd) begin
            st_d = ST_WAIT;
            set_cnt_d = SETTLE_CNT;
          end
        end
        ST_WAIT: begin
          if (set_cnt_q <= CNT_W'(1)) begin
            st_d = ST_DONE;
          end else begin
            set_cnt_d = set_cnt_q - CNT_W'(1);
          end
        end
        default: begin
          st_d = st_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      st_q <= ST_OFF;
      set_cnt_q <= '0;
    end else begin
      st_q <= st_d;
      set_cnt_q <= set_cnt_d;
    end
  end

  // ==========================================================
  // DQ drive
  assign fb_bits = {7'h00, fb[1], 7'h00, fb[0]};

  always_comb begin
    dq_d = 16'h0000;
    case (st_q)
      ST_ARMED, ST_WAIT: begin
        // Non-prime lines are undefined until settled; they echo the clock
        dq_d = (({16{ck_s}} & ~PRIME_MASK) | fb_bits) & lane_mask;
      end
      ST_DONE: begin
        dq_d = fb_bits & lane_mask;
      end
      default: begin
        dq_d = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      dq_q <= 16'h0000;
    end else begin
      dq_q <= dq_d;
    end
  end

  assign dq_out = dq_q;
  assign dq_oe_out = active ? lane_mask : 16'h0000;
  assign dqs_rx_en_out = active;

  // ==========================================================
  // Termination
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      dq_term_q <= 1'b0;
    end else begin
      // DQ termination is held off for the whole of leveling
      dq_term_q <= !ctrl_q.lvl_en && odt_s && rtt_on;
    end
  end

  assign dqs_term_en_out = dqs_term_q;
  assign dq_term_en_out = dq_term_q;

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rtt_bad_q <= 1'b0;
    end else begin
      // Standby accepts every code; driving leveling allows three
      rtt_bad_q <= lvl_live && !rtt_ok;
    end
  end

  // ==========================================================
  // APB slave
  assign setup = psel_in && !penable_in;
  assign access = psel_in && penable_in;

  assign stat.st = st_q;
  assign stat.rtt_bad = rtt_bad_q;
  assign stat.fb = fb;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr_in == CTRL_OFS) begin
      rd_mux = {26'h0, ctrl_q};
    end else if (paddr_in == STAT_OFS) begin
      rd_mux = {24'h00_0000, stat};
    end else if (paddr_in == CAPS_OFS) begin
      rd_mux = {16'h0000, caps_q[1], caps_q[0]};
    end else begin
      rd_err = 1'b1;
    end
  end

  // Read data is frozen in the setup cycle, giving one flop stage
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup) begin
      rdata_q <= pwrite_in ? 32'h0000_0000 : rd_mux;
      err_q <= rd_err;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ctrl_q <= CTRL_RST;
    end else if (access && pwrite_in && paddr_in == CTRL_OFS && pstrb_in[0]) begin
      ctrl_q <= pwdata_in[5:0];
    end
  end

  assign pready_out = access;
  assign prdata_out = rdata_q;
  assign pslverr_out = access && err_q;

  // ==========================================================
  // Checks
  sequence s_first_fb;
    (st_q == ST_ARMED) && (|upd);
  endsequence

  sequence s_live_hold;
    lvl_live throughout (##CHK_SET 1'b1);
  endsequence

  chk_off_hiz: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !ctrl_q.lvl_en |=> (dq_oe_out == 16'h0000) && !dqs_rx_en_out)
    else $error("DQ still driven with leveling off");

  chk_stby_deaf: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    ctrl_q.lvl_en && ctrl_q.out_dis |=> !dqs_rx_en_out && (dq_oe_out == 16'h0000) && (cap == 2'b00))
    else $error("strobe not ignored with outputs disabled");

  chk_rtt_flag: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    lvl_live && (ctrl_q.rtt == RTT_OFF || ctrl_q.rtt > RTT_40) |=> rtt_bad_q)
    else $error("illegal termination not flagged");

  chk_dir_turn: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    lvl_live |=> dqs_rx_en_out && dq_oe_out[0])
    else $error("buffers not turned for leveling");

  chk_enter_drive: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (st_q == ST_OFF) && lvl_live |=> dq_oe_out[0] && !$past(dq_oe_out[0]))
    else $error("DQ did not leave high-Z on entry");

  chk_other_low: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (st_q == ST_DONE) && $past(st_q == ST_DONE) |-> ((dq_out & ~PRIME_MASK) == 16'h0000))
    else $error("non-prime DQ not low");

  chk_prime_x16: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (st_q == ST_DONE) && $past(st_q == ST_DONE) && $past(ctrl_q.x16) |-> dq_out[8] == $past(fb[1]))
    else $error("upper prime DQ wrong");

  chk_term_split: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    ctrl_q.lvl_en |=> !dq_term_en_out && (dqs_term_en_out[0] == $past(odt_s && rtt_on)))
    else $error("termination wrong during leveling");

  chk_settle_time: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    s_first_fb ##0 s_live_hold |=> (st_q == ST_DONE))
    else $error("other lines not settled in time");

endmodule // wlv_level
`default_nettype wire

//--- verification/wlv_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Leveling controller: moves CK level, ODT and true strobes only
module wlv_ctrl_model import wlv_pkg::*; #(
  parameter int MOD_CYC = 4,
  parameter int WAIT_CYC = 3
) (
  input wire logic clk_sys_in,
  output logic ck_out,
  output logic odt_out,
  output logic [1:0] dqs_out
);
  // No command port: only NOP or deselect ever reach the device
  initial begin
    ck_out = 1'b0;
    odt_out = 1'b0;
    dqs_out = 2'b00;
  end
  // Called right after a mode write to the control register
  task automatic arm();
    // Termination stays off until the new mode is in force
    odt_out <= 1'b0;
    repeat (MOD_CYC) @(posedge clk_sys_in);
    odt_out <= 1'b1;
    repeat (WAIT_CYC) @(posedge clk_sys_in);
  endtask
  // CK held steady across the rise so the sampled level is unambiguous
  task automatic toggle(input logic [1:0] lanes, input logic ck);
    ck_out <= ck;
    repeat (3) @(posedge clk_sys_in);
    dqs_out <= lanes;
    repeat (4) @(posedge clk_sys_in);
    dqs_out <= 2'b00;
    repeat (FB_DELAY_CYC + 6) @(posedge clk_sys_in);
  endtask
  task automatic quit();
    odt_out <= 1'b0;
    repeat (MOD_CYC) @(posedge clk_sys_in);
  endtask
endmodule // wlv_ctrl_model
`default_nettype wire

//--- verification/ddr3_write_leveling_test.sv
`timescale 1ns/1ps
`default_nettype none
module ddr3_write_leveling_test import wlv_pkg::*;;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ck, odt, rx_en, dq_term;
  logic [1:0] dqs, dqs_term;
  logic [15:0] dq, dq_oe;
  logic lvl = 1'b0, dis = 1'b0, x16m = 1'b0;
  logic [2:0] rtt = 3'h0;
  logic [1:0] fbx = 2'b00;
  logic [31:0] rng = 32'h00014568;
  int caps[2] = '{0, 0};
  int fails = 0, tests_run = 0, cycles = 0, edge_pos, d;

  always #4 clk_sys_in = ~clk_sys_in;

  wlv_level dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .ck_in(ck), .odt_in(odt), .dqs_in(dqs), .dq_out(dq),
    .dq_oe_out(dq_oe), .dqs_rx_en_out(rx_en), .dqs_term_en_out(dqs_term), .dq_term_en_out(dq_term));
  wlv_ctrl_model model (.clk_sys_in(clk_sys_in), .ck_out(ck), .odt_out(odt), .dqs_out(dqs));

  // ==========================================================
  // Checking and bus helpers
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pin(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] st,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    @(posedge clk_sys_in);
    // Only the cycle ceiling ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge clk_sys_in);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, 4'h0, r, e);
    chk_reg(what, exp & m, r & m);
    chk_reg("pslverr", {31'h0, a > CAPS_OFS}, {31'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, v, st, r, e);
  endtask
  task automatic set_ctl(input logic e, input logic o, input logic [2:0] r, input logic x);
    lvl = e;
    dis = o;
    rtt = r;
    x16m = x;
    wr(CTRL_OFS, {26'h0, x, r, o, e}, 4'hf);
  endtask
  function automatic logic [15:0] oe_exp();
    return (lvl && !dis) ? (x16m ? LANE_MASK_X16 : LANE_MASK_X8) : 16'h0000;
  endfunction
  task automatic chk_pins();
    repeat (4) @(posedge clk_sys_in);
    chk_pin("dq_oe", oe_exp(), dq_oe);
    chk_pin("dqs_rx_en", {15'h0, lvl && !dis}, {15'h0, rx_en});
    chk_pin("dq_term", {15'h0, !lvl && odt && rtt != RTT_OFF}, {15'h0, dq_term});
    chk_pin("dqs_term", {14'h0, {x16m, 1'b1} & {2{odt && rtt != RTT_OFF}}}, {14'h0, dqs_term});
  endtask
  task automatic strobe(input logic [1:0] lanes, input logic c);
    model.toggle(lanes, c);
    for (int l = 0; l < 2; l++) begin
      if (lanes[l] && lvl && !dis && (l == 0 || x16m)) begin
        fbx[l] = c;
        caps[l]++;
      end
    end
    chk_pin("dq", {7'h00, fbx[1] & x16m, 7'h00, fbx[0]} & oe_exp(), dq & oe_exp());
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rd_chk("ctrl", CTRL_OFS, 32'h00000000, 32'hffffffff);
    wr(STAT_OFS, 32'hffffffff, 4'hf);
    rd_chk("stat", STAT_OFS, {24'h0, ST_OFF, 3'h0}, 32'hffffffff);
    rd_chk("unmapped", 8'h0c, 32'h00000000, 32'hffffffff);
    set_ctl(1'b0, 1'b0, RTT_60, 1'b0);
    model.arm();
    strobe(2'b01, 1'b1);
    chk_pins();
    for (int k = 0; k < 14; k++) begin
      set_ctl(1'b1, k < 7, 3'(k % 7 + 1), 1'b0);
      rd_chk("rtt_bad", STAT_OFS, {24'h0, ST_STBY, k >= 10, 2'b00}, (k < 7) ? 32'hfc : 32'h04);
    end
    set_ctl(1'b1, 1'b1, RTT_120, 1'b1);
    strobe(2'b11, 1'b1);
    chk_pins();
    set_ctl(1'b0, 1'b0, RTT_40, 1'b0);
    set_ctl(1'b1, 1'b0, RTT_40, 1'b0);
    model.arm();
    chk_pins();
    edge_pos = 1 + int'(rnd() % 32'd6);
    d = 0;
    while (fbx[0] !== 1'b1 && d < 8) begin
      strobe(2'b01, d >= edge_pos);
      strobe(2'b10, 1'b1);
      d++;
    end
    rd_chk("stat", STAT_OFS, {24'h0, ST_DONE, 1'b0, fbx}, 32'hff);
    rd_chk("caps", CAPS_OFS, {16'h0, 8'(caps[1]), 8'(caps[0])}, 32'hffff);
    wr(CAPS_OFS, 32'h00000000, 4'h1);
    caps[0] = 0;
    set_ctl(1'b1, 1'b0, RTT_120, 1'b1);
    repeat (8) begin
      strobe(2'(rnd() % 32'd3 + 32'd1), rnd() % 32'd2 == 32'd1);
    end
    rd_chk("caps", CAPS_OFS, {16'h0, 8'(caps[1]), 8'(caps[0])}, 32'hffff);
    model.quit();
    set_ctl(1'b0, 1'b0, RTT_120, 1'b1);
    chk_pins();
    finish_test();
  end
endmodule // ddr3_write_leveling_test
`default_nettype wire
